// ---- common/prf_pkg.sv ----
// constants for the paged register file
package prf_pkg;
    // ************************************************************
    // address map
    // ************************************************************
    localparam logic [7:0] GROUP_D_BASE = 8'hd0;
    localparam logic [7:0] SYS_BASE = 8'he0;
    localparam logic [7:0] WINDOW_BASE = 8'hf0;
    localparam int GP_COUNT = 224;
    localparam int SYS_COUNT = 16;
    localparam int PAGE_COUNT = 64;
    localparam int PAGE_WIDTH = 6;
    localparam int BLOCK_WIDTH = 5;
    // ************************************************************
    // system register offsets
    // ************************************************************
    localparam logic [7:0] PORT0_DATA = 8'he0;
    localparam logic [7:0] PORT1_DATA = 8'he1;
    localparam logic [7:0] PORT2_DATA = 8'he2;
    localparam logic [7:0] PORT3_DATA = 8'he3;
    localparam logic [7:0] PORT4_DATA = 8'he4;
    localparam logic [7:0] PORT5_DATA = 8'he5;
    localparam logic [7:0] INTERRUPT_CONTROL = 8'he6;
    localparam logic [7:0] FLAG_REGISTER = 8'he7;
    localparam logic [7:0] WORKING_BLOCK_POINTER_0 = 8'he8;
    localparam logic [7:0] WORKING_BLOCK_POINTER_1 = 8'he9;
    localparam logic [7:0] PAGE_SELECT = 8'hea;
    localparam logic [7:0] MODE_REGISTER = 8'heb;
    localparam logic [7:0] USER_STACK_HIGH = 8'hec;
    localparam logic [7:0] USER_STACK_LOW = 8'hed;
    localparam logic [7:0] SYSTEM_STACK_HIGH = 8'hee;
    localparam logic [7:0] SYSTEM_STACK_LOW = 8'hef;
    // ************************************************************
    // reset values and fields
    // ************************************************************
    localparam logic [7:0] INTERRUPT_CONTROL_RST = 8'h87;
    localparam logic [7:0] FLAG_REGISTER_RST = 8'h00;
    localparam logic [7:0] POINTER_RST = 8'h00;
    localparam logic [7:0] PAGE_SELECT_RST = 8'h00;
    localparam logic [7:0] OTHER_SYS_RST = 8'h00;
    localparam logic SINGLE_MODE_RST = 1'b1;
    localparam int GLOBAL_COUNTER_ENABLE_BIT = 7;
    localparam int TOP_LEVEL_PENDING_BIT = 6;
    localparam int TOP_LEVEL_SELECT_BIT = 5;
    localparam int INTERRUPT_ENABLE_BIT = 4;
    localparam int ARBITRATION_MODE_BIT = 3;
    localparam int PRIORITY_LSB = 0;
    localparam int PRIORITY_WIDTH = 3;
    localparam int BLOCK_LSB = 3;
endpackage

// ---- rtl/prf_paged_register_file.sv ----
// paged register file: general, system and peripheral-page registers
// ************************************************************
// Contract
// - 224 byte registers sit at addresses 0 to 223 in groups 0 to d.
// - sixteen system registers sit at 224 to 239, reachable by any mode.
// - addresses 240+n reach register n of the page chosen by page_select.
// - the page choice holds until page_select is written again.
// - a page exists only when its peripheral is present, at fixed spots.
// - direct 8-bit addresses reach everything except 208 to 223.
// - group d is reached only through working-register addressing.
// - a 4-bit working index is relocated through the block pointers.
// - working space is one block of sixteen or two blocks of eight.
// - pointers name one of 32 eight-register blocks, lower one if single.
// - setting both pointers picks single mode, setting one picks twin.
// - system group holds ports, interrupt, flags, pointers, page, stacks.
// - interrupt_control resets to 87h with its fixed bit layout.
// - accesses use a dedicated 8-bit address bus and 8-bit data bus.
// ************************************************************
module prf_paged_register_file (
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    input wire logic rd_en_in,
    input wire logic wr_en_in,
    input wire logic working_mode_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [3:0] work_index_in,
    input wire logic [7:0] wr_data_in,
    input wire logic set_pointers_in,
    input wire logic set_pointer_zero_in,
    input wire logic set_pointer_one_in,
    input wire logic [4:0] pointer_block_in,
    input wire logic [63:0] page_present_in,
    input wire logic [7:0] page_rdata_in,
    output logic [7:0] rd_data_out,
    output logic rd_valid_out,
    output logic [5:0] page_sel_out,
    output logic [3:0] page_reg_out,
    output logic page_rd_out,
    output logic page_wr_out,
    output logic [7:0] page_wdata_out,
    output logic [7:0] interrupt_control_out,
    output logic [7:0] flag_out,
    output logic [7:0] mode_out,
    output logic [7:0] pointer0_out,
    output logic [7:0] pointer1_out,
    output logic single_mode_out
);
    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        logic [prf_pkg::GP_COUNT-1:0][7:0] gp;
        logic [prf_pkg::SYS_COUNT-1:0][7:0] sys;
        logic single;
        logic [7:0] rd_data;
        logic rd_valid;
    } prf_state_type;

    prf_state_type state;
    prf_state_type next_state;
    logic [7:0] eff_addr;
    logic [7:0] rp0;
    logic [7:0] rp1;
    logic [5:0] cur_page;
    logic blocked;
    logic in_gp;
    logic in_sys;
    logic in_window;
    logic page_ok;
    logic [3:0] sys_idx;

    assign rp0 = state.sys[4'(prf_pkg::WORKING_BLOCK_POINTER_0)];
    assign rp1 = state.sys[4'(prf_pkg::WORKING_BLOCK_POINTER_1)];
    assign cur_page = state.sys[4'(prf_pkg::PAGE_SELECT)][5:0];

    // ************************************************************
    // address resolution
    // ************************************************************
    always_comb begin
        if (working_mode_in) begin
            if (state.single) begin
                // sixteen consecutive registers from the lower block
                // the sum wraps at 8 bits, so a top block runs into group 0
                eff_addr = 8'({rp0[7:prf_pkg::BLOCK_LSB], 3'h0}
                    + {4'h0, work_index_in});
            end else if (work_index_in[3]) begin
                eff_addr = {rp1[7:prf_pkg::BLOCK_LSB],
                    work_index_in[2:0]};
            end else begin
                eff_addr = {rp0[7:prf_pkg::BLOCK_LSB],
                    work_index_in[2:0]};
            end
        end else begin
            eff_addr = reg_addr_in;
        end
    end

    // direct addresses into group d select nothing
    assign blocked = !working_mode_in
        && reg_addr_in >= prf_pkg::GROUP_D_BASE
        && reg_addr_in < prf_pkg::SYS_BASE;
    assign in_gp = eff_addr < prf_pkg::SYS_BASE && !blocked;
    assign in_sys = eff_addr >= prf_pkg::SYS_BASE
        && eff_addr < prf_pkg::WINDOW_BASE;
    assign in_window = eff_addr >= prf_pkg::WINDOW_BASE;
    assign page_ok = page_present_in[cur_page];
    assign sys_idx = eff_addr[3:0];

    // ************************************************************
    // peripheral page port
    // ************************************************************
    // strobes follow the request combinationally so a page read lands
    // in the same cycle as any other read
    assign page_sel_out = cur_page;
    assign page_reg_out = eff_addr[3:0];
    assign page_rd_out = rd_en_in && in_window && page_ok;
    assign page_wr_out = wr_en_in && in_window && page_ok;
    assign page_wdata_out = wr_data_in;

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        next_state = state;
        next_state.rd_valid = rd_en_in;
        next_state.rd_data = 8'h00;
        if (rd_en_in) begin
            if (in_gp) begin
                next_state.rd_data = state.gp[eff_addr];
            end else if (in_sys) begin
                next_state.rd_data = state.sys[sys_idx];
            end else if (in_window && page_ok) begin
                next_state.rd_data = page_rdata_in;
            end else begin
                next_state.rd_data = 8'h00;
            end
        end
        if (wr_en_in) begin
            if (in_gp) begin
                next_state.gp[eff_addr] = wr_data_in;
            end else if (in_sys) begin
                next_state.sys[sys_idx] = wr_data_in;
            end
        end
        // pointer-setting commands win over a plain register write
        if (set_pointers_in) begin
            next_state.sys[4'(prf_pkg::WORKING_BLOCK_POINTER_0)] =
                {pointer_block_in, 3'h0};
            next_state.sys[4'(prf_pkg::WORKING_BLOCK_POINTER_1)] =
                {5'(pointer_block_in + 5'h01), 3'h0};
            next_state.single = 1'b1;
        end else begin
            if (set_pointer_zero_in) begin
                next_state.sys[4'(prf_pkg::WORKING_BLOCK_POINTER_0)] =
                    {pointer_block_in, 3'h0};
                next_state.single = 1'b0;
            end
            if (set_pointer_one_in) begin
                next_state.sys[4'(prf_pkg::WORKING_BLOCK_POINTER_1)] =
                    {pointer_block_in, 3'h0};
                next_state.single = 1'b0;
            end
        end
    end

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            state <= '0;
            state.sys[4'(prf_pkg::INTERRUPT_CONTROL)] <=
                prf_pkg::INTERRUPT_CONTROL_RST;
            state.sys[4'(prf_pkg::FLAG_REGISTER)] <=
                prf_pkg::FLAG_REGISTER_RST;
            state.sys[4'(prf_pkg::WORKING_BLOCK_POINTER_0)] <=
                prf_pkg::POINTER_RST;
            state.sys[4'(prf_pkg::WORKING_BLOCK_POINTER_1)] <=
                prf_pkg::POINTER_RST;
            state.sys[4'(prf_pkg::PAGE_SELECT)] <=
                prf_pkg::PAGE_SELECT_RST;
            state.single <= prf_pkg::SINGLE_MODE_RST;
        end else begin
            state <= next_state;
        end
    end

    assign rd_data_out = state.rd_data;
    assign rd_valid_out = state.rd_valid;
    assign interrupt_control_out =
        state.sys[4'(prf_pkg::INTERRUPT_CONTROL)];
    assign flag_out = state.sys[4'(prf_pkg::FLAG_REGISTER)];
    assign mode_out = state.sys[4'(prf_pkg::MODE_REGISTER)];
    assign pointer0_out = rp0;
    assign pointer1_out = rp1;
    assign single_mode_out = state.single;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (sys_rst_in);

    logic past_rst;
    always_ff @(posedge mclk_in) begin
        past_rst <= sys_rst_in;
    end

    sequence s_direct_gp_write;
        wr_en_in && !working_mode_in && reg_addr_in < prf_pkg::GROUP_D_BASE
            && !set_pointers_in;
    endsequence

    sequence s_same_read;
        rd_en_in && !wr_en_in && !working_mode_in
            && reg_addr_in == $past(reg_addr_in);
    endsequence

    sequence s_direct_sys_write;
        wr_en_in && !working_mode_in && reg_addr_in[7:4] == 4'he
            && !set_pointers_in && !set_pointer_zero_in
            && !set_pointer_one_in;
    endsequence

    a_reset_int_ctrl: assert property (
        past_rst && !sys_rst_in
            |-> interrupt_control_out == prf_pkg::INTERRUPT_CONTROL_RST
            && pointer0_out == prf_pkg::POINTER_RST
            && page_sel_out == prf_pkg::PAGE_SELECT_RST[5:0])
        else $error("interrupt control or pointer reset value wrong");

    a_gp_write_read: assert property (
        s_direct_gp_write ##1 s_same_read
            |=> rd_data_out == $past(wr_data_in, 2))
        else $error("general register did not return written byte");

    a_group_d_blocked: assert property (
        rd_en_in && !working_mode_in && reg_addr_in[7:4] == 4'hd
            |=> rd_valid_out && rd_data_out == 8'h00)
        else $error("direct read reached group d");

    a_missing_page_zero: assert property (
        rd_en_in && !working_mode_in && reg_addr_in[7:4] == 4'hf
            && !page_present_in[page_sel_out]
            |-> !page_rd_out ##1 rd_data_out == 8'h00)
        else $error("missing page did not read zero");

    a_page_select_hold: assert property (
        !(wr_en_in && in_sys && sys_idx == 4'(prf_pkg::PAGE_SELECT))
            |=> page_sel_out == $past(page_sel_out))
        else $error("page choice changed without a write");

    a_page_write_strobe: assert property (
        wr_en_in && !working_mode_in && reg_addr_in[7:4] == 4'hf
            && page_present_in[page_sel_out]
            |-> page_wr_out && page_reg_out == reg_addr_in[3:0])
        else $error("paged write not passed to peripheral");

    a_single_mode_set: assert property (
        set_pointers_in |=> single_mode_out
            && pointer0_out == {$past(pointer_block_in), 3'h0})
        else $error("set both pointers did not pick single mode");

    a_twin_mode_set: assert property (
        !set_pointers_in && set_pointer_one_in
            |=> !single_mode_out
            && pointer1_out == {$past(pointer_block_in), 3'h0})
        else $error("set one pointer did not pick twin mode");

    a_twin_relocate: assert property (
        working_mode_in && !single_mode_out && work_index_in[3]
            |-> eff_addr == {pointer1_out[7:3], work_index_in[2:0]})
        else $error("twin upper index not relocated through pointer 1");

    a_single_relocate: assert property (
        working_mode_in && single_mode_out
            |-> eff_addr == 8'({pointer0_out[7:3], 3'h0}
                + {4'h0, work_index_in}))
        else $error("single mode index not relocated from lower block");

    a_read_answer: assert property (
        rd_en_in |=> rd_valid_out ##1 (rd_valid_out == $past(rd_en_in)))
        else $error("read answer not one cycle after request");

    a_idle_read_zero: assert property (
        !rd_en_in |=> !rd_valid_out && rd_data_out == 8'h00)
        else $error("idle cycle left read data or valid standing");

    a_sys_write_read: assert property (
        s_direct_sys_write ##1 s_same_read
            |=> rd_data_out == $past(wr_data_in, 2))
        else $error("system register did not return written byte");

    a_reset_pointers: assert property (
        past_rst && !sys_rst_in |-> pointer1_out == prf_pkg::POINTER_RST
            && single_mode_out == prf_pkg::SINGLE_MODE_RST
            && !rd_valid_out)
        else $error("pointer 1, mode or read valid reset value wrong");

    a_single_ptr1_next: assert property (
        set_pointers_in |=> pointer1_out
            == {5'($past(pointer_block_in) + 5'h01), 3'h0})
        else $error("set both pointers did not place the upper block");

    a_twin_zero_set: assert property (
        !set_pointers_in && set_pointer_zero_in
            |=> !single_mode_out
            && pointer0_out == {$past(pointer_block_in), 3'h0})
        else $error("set pointer 0 did not pick twin mode");

    a_twin_low_relocate: assert property (
        working_mode_in && !single_mode_out && !work_index_in[3]
            |-> eff_addr == {pointer0_out[7:3], work_index_in[2:0]})
        else $error("twin lower index not relocated through pointer 0");

    a_direct_addr: assert property (
        !working_mode_in |-> eff_addr == reg_addr_in)
        else $error("direct address was relocated");

    a_page_read_data: assert property (
        page_rd_out |=> rd_valid_out && rd_data_out == $past(page_rdata_in))
        else $error("paged read did not return peripheral byte");

    // a strobe outside the window or to an absent page would let a
    // peripheral latch bytes meant for the general registers
    a_strobe_in_window: assert property (
        page_rd_out || page_wr_out
            |-> eff_addr >= prf_pkg::WINDOW_BASE
            && page_present_in[page_sel_out])
        else $error("page strobe outside window or for absent page");

    a_missing_page_drop: assert property (
        wr_en_in && eff_addr >= prf_pkg::WINDOW_BASE
            && !page_present_in[page_sel_out]
            |-> !page_wr_out)
        else $error("write to absent page reached the peripheral");

    a_int_ctrl_store: assert property (
        wr_en_in && !working_mode_in
            && reg_addr_in == prf_pkg::INTERRUPT_CONTROL
            |=> interrupt_control_out == $past(wr_data_in))
        else $error("interrupt control did not take written byte");

    a_page_select_store: assert property (
        wr_en_in && !working_mode_in && reg_addr_in == prf_pkg::PAGE_SELECT
            |=> page_sel_out == $past(wr_data_in[5:0]))
        else $error("page choice did not follow page_select write");
endmodule

// ---- verification/prf_periph_model.sv ----
// peripheral page model seen through the group f window
module prf_periph_model (
    input wire logic mclk_in,
    input wire logic [5:0] page_sel_in,
    input wire logic [3:0] page_reg_in,
    input wire logic page_rd_in,
    input wire logic page_wr_in,
    input wire logic [7:0] page_wdata_in,
    output logic [7:0] page_rdata_out,
    output logic [63:0] page_present_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [0:63][0:15];
    logic [7:0] junk = 8'h3c;
    // only pages 0 and 5 exist; an absent page never latches data
    assign page_present_out = 64'h0000_0000_0000_0021;
    // idle bus shows a changing pattern so a stale value never matches
    assign page_rdata_out = page_rd_in ?
        mem[page_sel_in][page_reg_in] : junk;
    always @(posedge mclk_in) begin
        junk <= ~junk + 8'h01;
        if (page_wr_in && page_present_out[page_sel_in]) begin
            mem[page_sel_in][page_reg_in] <= page_wdata_in;
        end
    end
endmodule

// ---- verification/prf_paged_register_file_tb.sv ----
// self-checking bench for the paged register file
module prf_paged_register_file_tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e;} prf_row_type;
    logic mclk, rst, rd_en, wr_en, wm, setb, set0, set1;
    logic [7:0] addr, wdata, rdata, prdata, icr, p0, p1, pwdata, flg, mde;
    logic [3:0] idx, preg;
    logic [4:0] blk;
    logic [5:0] psel;
    logic [63:0] pres;
    logic rvalid, prd, pwr, single, seen_pwr;
    int err_total = 0;
    int cmp_count = 0;
    prf_row_type rows [9] = '{
        '{8'h00, 8'h11, 8'h11}, '{8'h7f, 8'h22, 8'h22},
        '{8'hcf, 8'h33, 8'h33}, '{8'hd5, 8'h44, 8'h00},
        '{8'he0, 8'h55, 8'h55}, '{8'he7, 8'h66, 8'h66},
        '{8'heb, 8'h77, 8'h77}, '{8'hec, 8'h88, 8'h88},
        '{8'hef, 8'h99, 8'h99}};
    prf_paged_register_file i_dut (.mclk_in(mclk), .sys_rst_in(rst),
        .rd_en_in(rd_en), .wr_en_in(wr_en), .working_mode_in(wm),
        .reg_addr_in(addr), .work_index_in(idx), .wr_data_in(wdata),
        .set_pointers_in(setb), .set_pointer_zero_in(set0),
        .set_pointer_one_in(set1), .pointer_block_in(blk),
        .page_present_in(pres), .page_rdata_in(prdata),
        .rd_data_out(rdata), .rd_valid_out(rvalid), .page_sel_out(psel),
        .page_reg_out(preg), .page_rd_out(prd), .page_wr_out(pwr),
        .page_wdata_out(pwdata), .interrupt_control_out(icr),
        .flag_out(flg), .mode_out(mde), .pointer0_out(p0), .pointer1_out(p1),
        .single_mode_out(single));
    prf_periph_model i_periph (.mclk_in(mclk), .page_sel_in(psel),
        .page_reg_in(preg), .page_rd_in(prd), .page_wr_in(pwr),
        .page_wdata_in(pwdata), .page_rdata_out(prdata),
        .page_present_out(pres));
    // ************************************************************
    // tasks
    // ************************************************************
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        cmp_count++;
        if (g !== e) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // one access; the page write strobe is sampled mid-cycle where it is settled
    task automatic acc(input logic we, input logic w, input logic [7:0] a,
                       input logic [3:0] ix, input logic [7:0] d);
        @(posedge mclk) #1;
        rd_en = !we;
        wr_en = we;
        wm = w;
        addr = a;
        idx = ix;
        wdata = d;
        @(negedge mclk) seen_pwr = pwr;
        @(posedge mclk) #1;
        rd_en = 1'b0;
        wr_en = 1'b0;
    endtask
    task automatic rdc(input logic w, input logic [7:0] a,
                       input logic [3:0] ix, input logic [7:0] e);
        acc(1'b0, w, a, ix, 8'h00);
        chk({7'h00, rvalid}, 8'h01);
        chk(rdata, e);
    endtask
    task automatic setp(input logic [2:0] k, input logic [4:0] b);
        @(posedge mclk) #1;
        {setb, set0, set1} = k;
        blk = b;
        @(posedge mclk) #1;
        {setb, set0, set1} = 3'b000;
    endtask
    // write, then read the same address on the very next edge
    task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk) #1;
        wm = 1'b0;
        wr_en = 1'b1;
        addr = a;
        wdata = d;
        @(posedge mclk) #1;
        wr_en = 1'b0;
        rd_en = 1'b1;
        @(posedge mclk) #1;
        rd_en = 1'b0;
        chk(rdata, d);
    endtask
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // ************************************************************
    // stimulus
    // ************************************************************
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    initial begin
        #100000;
        err_total++;
        end_sim();
    end
    initial begin
        {rst, rd_en, wr_en, wm, setb, set0, set1, seen_pwr} = 8'h80;
        {addr, wdata, idx, blk} = 25'h0;
        repeat (8) @(posedge mclk);
        #1 rst = 1'b0;
        chk(icr, 8'h87);
        chk(p0 | p1, 8'h00);
        chk({2'b00, psel}, 8'h00);
        chk({7'h00, single}, 8'h01);
        rdc(1'b0, 8'he6, 4'h0, 8'h87);
        $display("test reset done");
        foreach (rows[i]) begin
            acc(1'b1, 1'b0, rows[i].a, 4'h0, rows[i].d);
            rdc(1'b0, rows[i].a, 4'h0, rows[i].e);
        end
        chk(flg, 8'h66);
        chk(mde, 8'h77);
        $display("test rows done");
        setp(3'b100, 5'h02);
        chk({7'h00, single}, 8'h01);
        chk(p0, 8'h10);
        chk(p1, 8'h18);
        acc(1'b1, 1'b0, 8'h1c, 4'h0, 8'hc3);
        rdc(1'b1, 8'h00, 4'hc, 8'hc3);
        setp(3'b100, 5'h1a);
        acc(1'b1, 1'b1, 8'h00, 4'h5, 8'h3c);
        rdc(1'b0, 8'hd5, 4'h0, 8'h00);
        rdc(1'b1, 8'h00, 4'h5, 8'h3c);
        $display("test single done");
        setp(3'b010, 5'h0f);
        setp(3'b001, 5'h1d);
        chk({7'h00, single}, 8'h00);
        rdc(1'b1, 8'h00, 4'h8, 8'h78);
        rdc(1'b1, 8'h00, 4'h7, 8'h22);
        $display("test twin done");
        acc(1'b1, 1'b0, 8'hea, 4'h0, 8'h05);
        chk({2'b00, psel}, 8'h05);
        acc(1'b1, 1'b0, 8'hf2, 4'h0, 8'ha5);
        chk({7'h00, seen_pwr}, 8'h01);
        rdc(1'b0, 8'hf2, 4'h0, 8'ha5);
        rdc(1'b1, 8'h00, 4'ha, 8'h05);
        acc(1'b1, 1'b0, 8'hea, 4'h0, 8'h07);
        acc(1'b1, 1'b0, 8'hf2, 4'h0, 8'h5a);
        chk({7'h00, seen_pwr}, 8'h00);
        rdc(1'b0, 8'hf2, 4'h0, 8'h00);
        $display("test page done");
        wr_rd(8'h42, 8'h6d);
        wr_rd(8'hed, 8'h5e);
        // read and write of one register in one cycle: old byte returns
        @(posedge mclk) #1;
        rd_en = 1'b1;
        wr_en = 1'b1;
        addr = 8'h42;
        wdata = 8'h99;
        @(posedge mclk) #1;
        rd_en = 1'b0;
        wr_en = 1'b0;
        chk(rdata, 8'h6d);
        rdc(1'b0, 8'h42, 4'h0, 8'h99);
        $display("test back to back done");
        acc(1'b1, 1'b0, 8'he6, 4'h0, 8'h12);
        chk(icr, 8'h12);
        @(posedge mclk) #1;
        rst = 1'b1;
        repeat (2) @(posedge mclk);
        #1 rst = 1'b0;
        chk(icr, 8'h87);
        chk(p0 | p1, 8'h00);
        chk({2'b00, psel}, 8'h00);
        chk({7'h00, single}, 8'h01);
        rdc(1'b0, 8'h00, 4'h0, 8'h00);
        $display("test reset again done");
        end_sim();
    end
endmodule
